// File: tb.sv
// Self-checking bench for the two-wire register slave
`timescale 1ns/1ps
`include "two_wire_regs.svh"
module tb;
   localparam int TO_CYC = 2000;
   logic        i_clock = 1'b0;
   logic        i_rstn = 1'b0;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [3:0]  adr = 4'h0, sel = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, rd;
   logic        ack, scl0, sda0, dq0, oe0, scl1, sda1, dq1, oe1, irq_n, wake, p15s, p15w;
   logic [7:0]  dat [16], rg;
   integer      seed = 32'h592c;
   int          err_total = 0, checks = 0, wakes = 0;
   always #12.5 i_clock = ~i_clock;
   two_wire_register_slave #(.TIMEOUT_CYCLES(TO_CYC)) DUT (
      .i_clock(i_clock), .i_rstn(i_rstn), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
      .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
      .i_serial_clock_pin(scl0), .i_sda(sda0), .o_sda(dq0), .o_sda_oe(oe0),
      .i_scl2(scl1), .i_sda2(sda1), .o_sda2(dq1), .o_sda2_oe(oe1),
      .o_interrupt_request_out_n(irq_n), .o_wake(wake),
      .o_pin15_function_select(p15s), .o_pin15_wake_enable(p15w));
   two_wire_host m0 (.i_dev_sda(dq0), .i_dev_sda_oe(oe0), .o_scl(scl0), .o_sda(sda0));
   two_wire_host m1 (.i_dev_sda(dq1), .i_dev_sda_oe(oe1), .o_scl(scl1), .o_sda(sda1));
   // Wake is a pulse, so count it as it passes
   always @(posedge i_clock)
      if (wake === 1'b1) wakes <= wakes + 1;
   task automatic print_verdict();
      if (err_total == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Classic Wishbone cycle; data taken at the ack edge
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_clock);
      {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'hf, d};
      do begin
         @(posedge i_clock);
         n++;
      end while (ack !== 1'b1 && n < 40);
      chk(ack, 1'b1);
      rd = rdat;
      {cyc, stb} <= 2'b00;
      @(posedge i_clock);
   endtask : wb
   task automatic frame(input int p, input int s);
      if (s != 0)
         if (p != 0) m1.start(); else m0.start();
      else
         if (p != 0) m1.stop(); else m0.stop();
   endtask : frame
   task automatic tx(input int p, input logic [7:0] b, input logic e);
      logic a;
      if (p != 0) m1.send(b, a); else m0.send(b, a);
      chk(a, e);
   endtask : tx
   task automatic page_wr(input int p, input logic [7:0] dv, r, input int k, n);
      frame(p, 1);
      tx(p, dv, 1'b1);
      tx(p, r, 1'b1);
      for (int i = 0; i < n; i++)
         tx(p, dat[k + i], 1'b1);
      frame(p, 0);
   endtask : page_wr
   // Pointer write, then read n bytes against dat[k..]
   task automatic rd_n(input int p, input logic [7:0] dv, r, input int k, n, fresh);
      logic [7:0] b;
      frame(p, 1);
      tx(p, dv, 1'b1);
      tx(p, r, 1'b1);
      if (fresh != 0) frame(p, 0);
      frame(p, 1);
      tx(p, dv | 8'h01, 1'b1);
      for (int i = 0; i < n; i++) begin
         if (p != 0) m1.recv(i < n - 1, b); else m0.recv(i < n - 1, b);
         chk(b, dat[k + i]);
      end
      frame(p, 0);
   endtask : rd_n
   initial begin
      repeat (4) @(posedge i_clock);
      i_rstn <= 1'b1;
      repeat (4) @(posedge i_clock);
      // Reset values, then an unmapped offset reads zero
      wb(1'b0, `CTRL_OFS, 32'h0);
      chk(rd, `CTRL_RESET);
      wb(1'b0, `ADDR_OFS, 32'h0);
      chk(rd, `ADDR_RESET);
      wb(1'b0, 4'h2, 32'h0);
      chk(rd, 32'h0);
      for (int i = 0; i < 15; i++)
         dat[i] = 8'($random(seed));
      dat[15] = 8'h00;
      rg = {3'b010, 5'($random(seed))};
      page_wr(0, 8'hb0, rg, 0, 8);
      rd_n(0, 8'hb0, rg, 0, 8, 0);
      rd_n(0, 8'hb0, rg + 8'h07, 7, 1, 1);
      rd_n(0, 8'hb0, 8'h90, 15, 1, 0);
      rd_n(0, 8'hb0, `PAGE_CTRL_ADDR, 15, 1, 0);
      // Repeated write: non-consecutive pairs
      wb(1'b1, `CTRL_OFS, 32'h03);
      frame(0, 1);
      tx(0, 8'hb0, 1'b1);
      for (int i = 8; i < 12; i++) begin
         tx(0, 8'h08 + 8'(3 * i), 1'b1);
         tx(0, dat[i], 1'b1);
      end
      frame(0, 0);
      for (int i = 8; i < 12; i++)
         rd_n(0, 8'hb0, 8'h08 + 8'(3 * i), i, 1, 0);
      // Foreign address and master code stay unanswered
      frame(0, 1);
      tx(0, 8'hc0, 1'b0);
      tx(0, 8'h00, 1'b0);
      frame(0, 0);
      frame(0, 1);
      tx(0, {`MCODE_PREFIX, 3'($random(seed))}, 1'b0);
      wb(1'b0, `STATUS_OFS, 32'h0);
      chk(rd[`STAT_HS0], 1'b1);
      rd_n(0, 8'hb0, rg, 0, 2, 0);
      // Second port: off, then enabled with events
      frame(1, 1);
      tx(1, 8'hb4, 1'b0);
      frame(1, 0);
      wb(1'b1, `CTRL_OFS, 32'hc1);
      chk({p15s, p15w}, 2'b11);
      wb(1'b1, `CTRL_OFS, 32'hf1);
      chk({p15s, p15w}, 2'b00);
      wb(1'b1, `MASK_OFS, 32'h0);
      wb(1'b1, `STATUS_OFS, 32'h1);
      chk(irq_n, 1'b1);
      page_wr(1, 8'hb4, 8'h30, 12, 2);
      rd_n(1, 8'hb4, 8'h30, 12, 2, 0);
      wb(1'b0, `STATUS_OFS, 32'h0);
      chk(rd[`STAT_EVENT], 1'b1);
      chk({irq_n, wakes > 0}, 2'b01);
      wb(1'b1, `STATUS_OFS, 32'h1);
      chk(irq_n, 1'b1);
      rd_n(1, 8'hb4, 8'h30, 12, 1, 0);
      chk(irq_n, 1'b0);
      wb(1'b1, `MASK_OFS, 32'h1);
      chk(irq_n, 1'b1);
      // Stalled transfer is dropped only after the idle limit
      wb(1'b1, `CTRL_OFS, 32'h0d);
      frame(0, 1);
      tx(0, 8'hb0, 1'b1);
      repeat (TO_CYC - 100) @(posedge i_clock);
      wb(1'b0, `STATUS_OFS, 32'h0);
      chk(rd[`STAT_BUSY0], 1'b1);
      chk(rd[`STAT_HS0], 1'b1);
      repeat (200) @(posedge i_clock);
      wb(1'b0, `STATUS_OFS, 32'h0);
      chk(rd[`STAT_BUSY0], 1'b0);
      rd_n(0, 8'hb0, rg, 0, 1, 0);
      print_verdict();
   end
   // Watchdog well past the expected run length
   initial begin
      #2000000;
      err_total++;
      print_verdict();
   end
endmodule : tb

// File: two_wire_host.sv
// Behavioural two-wire bus master with open-drain data line
`timescale 1ns/1ps
module two_wire_host (
   // Device side of the data pin
   input  wire logic i_dev_sda,
   input  wire logic i_dev_sda_oe,
   // Resolved bus lines
   output logic      o_scl,
   output logic      o_sda
);
   logic pull_low;
   // Pull-up wins unless someone sinks the line
   assign o_sda = ~(pull_low | (i_dev_sda_oe & ~i_dev_sda));
   // Clock stands high outside frames
   initial begin
      o_scl    = 1'b1;
      pull_low = 1'b0;
   end
   // Start or repeated start; leaves clock low. The long low phase lets the
   // device finish releasing its acknowledge, or the clock rise reads as STOP
   task automatic start();
      pull_low = 1'b0;
      #140;
      o_scl = 1'b1;
      #80;
      pull_low = 1'b1;
      #80;
      o_scl = 1'b0;
   endtask : start
   // Stop, then an idle gap
   task automatic stop();
      #40;
      pull_low = 1'b1;
      #80;
      o_scl = 1'b1;
      #80;
      pull_low = 1'b0;
      #200;
   endtask : stop
   // One 200 ns bit: data set in low phase, sampled mid high
   task automatic bit_io(input logic b, output logic seen);
      #40;
      pull_low = ~b;
      #80;
      o_scl = 1'b1;
      #40;
      seen = o_sda;
      #40;
      o_scl = 1'b0;
   endtask : bit_io
   task automatic send(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_io(b[i], s);
      bit_io(1'b1, s);
      ack = ~s;
   endtask : send
   task automatic recv(input logic more, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, s);
         b[i] = s;
      end
      bit_io(~more, s);
   endtask : recv
endmodule : two_wire_host

// File: two_wire_pkg.sv
// Types shared by the two-wire register slave
package two_wire_pkg;
   typedef enum logic [2:0] {
      ST_IDLE, ST_DEV, ST_REG, ST_WDAT, ST_ACK, ST_RD, ST_MACK, ST_IGN
   } tw_state_t;
endpackage : two_wire_pkg

// File: two_wire_properties.sv
// Checker for the two-wire register slave pins
`timescale 1ns/1ps
`include "two_wire_regs.svh"
module two_wire_properties #(
   parameter int TIMEOUT_CYCLES = 2000
) (
   // Clock, reset, Wishbone
   input wire logic        i_clock,
   input wire logic        i_rstn,
   input wire logic        i_wb_cyc,
   input wire logic        i_wb_stb,
   input wire logic        i_wb_we,
   input wire logic [3:0]  i_wb_adr,
   input wire logic [3:0]  i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   input wire logic        o_wb_ack,
   // Serial pins
   input wire logic        i_serial_clock_pin,
   input wire logic        i_sda,
   input wire logic        o_sda_oe,
   input wire logic        i_scl2,
   input wire logic        o_sda2_oe,
   // System outputs
   input wire logic        o_interrupt_request_out_n,
   input wire logic        o_wake,
   input wire logic        o_pin15_function_select,
   input wire logic        o_pin15_wake_enable
);
   logic [7:0] ctrl, next_ctrl;
   logic       mask, next_mask, wr;
   // -----------------------------------------
   // Shadow of control and mask
   // -----------------------------------------
   always_comb begin
      wr        = i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack & i_wb_sel[0];
      next_ctrl = (wr && i_wb_adr == `CTRL_OFS) ? i_wb_dat[7:0] : ctrl;
      next_mask = (wr && i_wb_adr == `MASK_OFS) ? i_wb_dat[0] : mask;
   end
   // Updated at the ack edge; pin15, port2 and irq checks wait for the bus to go quiet
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         ctrl <= `CTRL_RESET;
         mask <= `MASK_RESET;
      end else begin
         ctrl <= next_ctrl;
         mask <= next_mask;
      end
   end
   // -----------------------------------------
   // Properties
   // -----------------------------------------
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rstn);
   chk_wb_ack_next: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
      else $error("wishbone ack late");
   chk_pin15_gated: assert property (
      !i_wb_cyc |-> {o_pin15_function_select, o_pin15_wake_enable} ==
         ({ctrl[`CTRL_PIN15_SEL], ctrl[`CTRL_PIN15_WEN]} & {2{!ctrl[`CTRL_PIN14_SEL]}}))
      else $error("pin15 controls not gated");
   chk_port2_off: assert property (
      !ctrl[`CTRL_PIN14_SEL] && !i_wb_cyc |-> !o_sda2_oe) else $error("second port drove");
   chk_irq_masked: assert property (
      mask && !i_wb_cyc |-> o_interrupt_request_out_n) else $error("masked irq seen");
   chk_wake_cause: assert property (
      o_wake |-> ctrl[`CTRL_PIN14_WEN] && ctrl[`CTRL_PIN14_SEL] ##1 !o_wake)
      else $error("wake without enable or too long");
   chk_oe_phase: assert property (
      $changed(o_sda_oe) |-> !i_serial_clock_pin) else $error("data moved, clock high");
   chk_oe2_phase: assert property (
      $changed(o_sda2_oe) |-> !i_scl2) else $error("port2 data moved, clock high");
   chk_stop_release: assert property (
      i_serial_clock_pin && $past(i_serial_clock_pin) && $rose(i_sda) |=> !o_sda_oe[*4])
      else $error("data driven after stop");
endmodule : two_wire_properties

bind two_wire_register_slave two_wire_properties #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_props (
   .i_clock(i_clock), .i_rstn(i_rstn), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
   .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
   .o_wb_ack(o_wb_ack), .i_serial_clock_pin(i_serial_clock_pin), .i_sda(i_sda),
   .o_sda_oe(o_sda_oe), .i_scl2(i_scl2), .o_sda2_oe(o_sda2_oe),
   .o_interrupt_request_out_n(o_interrupt_request_out_n), .o_wake(o_wake),
   .o_pin15_function_select(o_pin15_function_select),
   .o_pin15_wake_enable(o_pin15_wake_enable));

// File: two_wire_register_slave.sv
// Two-wire register slave: two serial ports, shared register space, Wishbone control
//
// Functional notes
// - Bytes are 8 bits; data is sampled on each serial clock rise.
// - Address and data bytes travel most significant bit first.
// - Data rising while clock high is STOP; port returns to idle.
// - Own 7-bit address is acknowledged by holding data low one clock.
// - Single write: address, register, data, STOP; every byte acknowledged.
// - Master not-acknowledge ends a read; device releases data line.
// - Master acknowledge advances pointer and sends next byte without limit.
// - Reading a non-existent register returns zero.
// - Write mode 0: one register address, many data bytes, pointer increments.
// - Write mode 1: register-data pairs repeat until STOP.
// - Second port has own write address, default b4, read b5.
// - Second port active only when pin14 selects second-bus data.
// - Second port enabled forces pin15 select and wake enable off.
// - Matching second-port access sets event flag, interrupt, optional wake.
// - Event flag re-asserts on each access; mask it while in use.
// - Second port otherwise equals primary; high speed by code or config.
// - Master code 0000 1xxx enters high speed for that transfer.
// - No clock stretching; read data ready without added delay.
// - With timeout enabled, idle clock beyond 35 ms resets the port.
// - Register zero is page control; page LSB ignored.
`timescale 1ns/1ps
`include "two_wire_regs.svh"

// -----------------------------------------------------------------
// Serial protocol engine, one per port
// -----------------------------------------------------------------
module two_wire_engine
   import two_wire_pkg::*;
#(
   parameter int TIMEOUT_CYCLES = `TIMEOUT_MS * `CLOCK_KHZ
) (
   // Clock and reset
   input  wire logic       i_clock,
   input  wire logic       i_rstn,
   // Serial pins
   input  wire logic       i_scl,
   input  wire logic       i_sda,
   output logic            o_sda_o,
   output logic            o_sda_oe,
   // Configuration
   input  wire logic       i_enable,
   input  wire logic [7:0] i_dev_addr,
   input  wire logic       i_write_mode,
   input  wire logic       i_timeout_en,
   input  wire logic       i_hs_cont,
   // Register space access
   input  wire logic [7:0] i_rd_data,
   output logic      [7:0] o_ptr,
   output logic            o_we,
   output logic      [7:0] o_wdata,
   // Status
   output logic            o_match,
   output logic            o_busy,
   output logic            o_hs
);
   // Pin synchronisers; the third stage only feeds edge detection
   logic [2:0] scl_s;
   logic [2:0] sda_s;
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         scl_s <= 3'h7;
         sda_s <= 3'h7;
      end else begin
         scl_s <= {scl_s[1:0], i_scl};
         sda_s <= {sda_s[1:0], i_sda};
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   assign scl_rise = scl_s[1] & ~scl_s[2];
   assign scl_fall = ~scl_s[1] & scl_s[2];
   assign start_c  = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
   assign stop_c   = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];

   tw_state_t   state, next_state;
   tw_state_t   after, next_after;
   logic [3:0]  cnt, next_cnt;
   logic [7:0]  sh, next_sh;
   logic [7:0]  ptr, next_ptr;
   logic        oe, next_oe;
   logic        rd, next_rd;
   logic        mack, next_mack;
   logic        hs, next_hs;
   logic        we, next_we;
   logic        match, next_match;
   logic [20:0] idle_cnt, next_idle_cnt;

   // Byte and bit sequencing
   always_comb begin
      next_state    = state;
      next_after    = after;
      next_cnt      = cnt;
      next_sh       = sh;
      next_ptr      = ptr;
      next_oe       = oe;
      next_rd       = rd;
      next_mack     = mack;
      next_hs       = hs;
      next_we       = 1'b0;
      next_match    = 1'b0;
      next_idle_cnt = idle_cnt;
      // Idle-clock watchdog counts only inside a transaction
      if (state == ST_IDLE || scl_rise || scl_fall)
         next_idle_cnt = '0;
      else if (idle_cnt != 21'h1fffff)
         next_idle_cnt = idle_cnt + 21'h1;
      if (!i_enable) begin
         next_state = ST_IDLE;
         next_oe    = 1'b0;
         next_hs    = 1'b0;
      end else if (i_timeout_en && idle_cnt >= 21'(TIMEOUT_CYCLES)) begin
         next_state = ST_IDLE;
         next_oe    = 1'b0;
         next_hs    = 1'b0;
      end else if (start_c) begin
         next_state = ST_DEV;
         next_cnt   = 4'h0;
         next_oe    = 1'b0;
      end else if (stop_c) begin
         next_state = ST_IDLE;
         next_oe    = 1'b0;
         next_hs    = 1'b0;
      end else begin
         case (state)
            ST_DEV, ST_REG, ST_WDAT: begin
               if (scl_rise && cnt < 4'h8) begin
                  next_sh  = {sh[6:0], sda_s[1]};
                  next_cnt = cnt + 4'h1;
               end else if (scl_fall && cnt == 4'h8) begin
                  next_oe    = 1'b1;
                  next_state = ST_ACK;
                  if (state == ST_DEV) begin
                     if (sh[7:3] == `MCODE_PREFIX) begin
                        next_oe    = 1'b0;
                        next_hs    = 1'b1;
                        next_state = ST_IGN;
                     end else if (sh[7:1] == i_dev_addr[7:1]) begin
                        next_match = 1'b1;
                        next_rd    = sh[0];
                        next_after = sh[0] ? ST_RD : ST_REG;
                     end else begin
                        next_oe    = 1'b0;
                        next_state = ST_IGN;
                     end
                  end else if (state == ST_REG) begin
                     next_ptr   = sh;
                     next_after = ST_WDAT;
                  end else begin
                     next_we = 1'b1;
                     next_after = i_write_mode ? ST_REG : ST_WDAT;
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  next_cnt   = 4'h0;
                  next_state = after;
                  next_oe    = 1'b0;
                  if (after == ST_RD)
                     next_oe = ~i_rd_data[7];
                  next_sh = i_rd_data;
               end
            end
            ST_RD: begin
               if (scl_rise)
                  next_cnt = cnt + 4'h1;
               else if (scl_fall) begin
                  if (cnt == 4'h8) begin
                     next_oe    = 1'b0;
                     next_state = ST_MACK;
                  end else begin
                     next_sh = {sh[6:0], 1'b0};
                     next_oe = ~sh[6];
                  end
               end
            end
            ST_MACK: begin
               if (scl_rise) begin
                  next_mack = ~sda_s[1];
                  if (!sda_s[1])
                     next_ptr = ptr + 8'h1;
               end else if (scl_fall) begin
                  next_cnt = 4'h0;
                  if (mack) begin
                     next_state = ST_RD;
                     next_sh    = i_rd_data;
                     next_oe    = ~i_rd_data[7];
                  end else
                     next_state = ST_IGN;
               end
            end
            ST_IDLE, ST_IGN: next_oe = 1'b0;
            default: begin
               next_state = ST_IDLE;
               next_oe    = 1'b0;
            end
         endcase
      end
   end

   // Page write pointer advances after the byte is stored
   logic [7:0] wptr;
   assign wptr = ptr;

   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         state    <= ST_IDLE;
         after    <= ST_IDLE;
         cnt      <= 4'h0;
         sh       <= 8'h00;
         ptr      <= 8'h00;
         oe       <= 1'b0;
         rd       <= 1'b0;
         mack     <= 1'b0;
         hs       <= 1'b0;
         we       <= 1'b0;
         match    <= 1'b0;
         idle_cnt <= '0;
      end else begin
         state    <= next_state;
         after    <= next_after;
         cnt      <= next_cnt;
         sh       <= next_sh;
         oe       <= next_oe;
         rd       <= next_rd;
         mack     <= next_mack;
         hs       <= next_hs;
         we       <= next_we;
         match    <= next_match;
         idle_cnt <= next_idle_cnt;
         // Pointer moves on after a page-mode store
         if (we && !i_write_mode)
            ptr <= wptr + 8'h1;
         else
            ptr <= next_ptr;
      end
   end

   // Data written is the byte just received at the current pointer
   assign o_we     = we;
   assign o_wdata  = sh;
   assign o_ptr    = ptr;
   assign o_sda_o  = 1'b0;
   assign o_sda_oe = oe;
   assign o_match  = match;
   assign o_busy   = (state != ST_IDLE);
   assign o_hs     = hs | i_hs_cont;
endmodule : two_wire_engine

// -----------------------------------------------------------------
// Top level: register space, two ports, Wishbone control
// -----------------------------------------------------------------
module two_wire_register_slave
   import two_wire_pkg::*;
#(
   parameter int TIMEOUT_CYCLES = `TIMEOUT_MS * `CLOCK_KHZ
) (
   // Clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_rstn,
   // Wishbone slave
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [3:0]  i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic      [31:0] o_wb_dat,
   output logic             o_wb_ack,
   // Primary port pins
   input  wire logic        i_serial_clock_pin,
   input  wire logic        i_sda,
   output logic             o_sda,
   output logic             o_sda_oe,
   // Second port pins
   input  wire logic        i_scl2,
   input  wire logic        i_sda2,
   output logic             o_sda2,
   output logic             o_sda2_oe,
   // System outputs
   output logic             o_interrupt_request_out_n,
   output logic             o_wake,
   output logic             o_pin15_function_select,
   output logic             o_pin15_wake_enable
);
   logic [7:0]  ctrl;
   logic [15:0] base;
   logic        flag;
   logic        mask;
   logic        page;
   logic [7:0]  mem [0:511];

   logic [1:0]       busy, hs, match, we;
   logic [1:0][7:0]  ptr, wdata, rdata;
   logic [1:0]       en;
   logic [1:0][7:0]  dev;

   // Second port lives only while pin14 selects its data function
   assign en[0]  = ctrl[`CTRL_PORT_EN];
   assign en[1]  = ctrl[`CTRL_PIN14_SEL];
   assign dev[0] = base[7:0];
   assign dev[1] = base[15:8];

   // Register read decode shared by both ports
   function automatic logic [7:0] reg_read(input logic [7:0] a, input logic p,
                                            input logic [7:0] d);
      if (a == `PAGE_CTRL_ADDR)
         reg_read = {6'h00, p, 1'b0};
      else if (a >= `REG_LIMIT)
         reg_read = 8'h00;
      else
         reg_read = d;
   endfunction : reg_read

   // Both ports built from one engine
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_port
         logic scl_in;
         logic sda_in;
         logic sda_o;
         logic sda_oe;
         assign scl_in = (g == 0) ? i_serial_clock_pin : i_scl2;
         assign sda_in = (g == 0) ? i_sda : i_sda2;
         assign rdata[g] = reg_read(ptr[g], page, mem[{page, ptr[g]}]);
         two_wire_engine #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_engine (
            .i_clock      (i_clock),
            .i_rstn       (i_rstn),
            .i_scl        (scl_in),
            .i_sda        (sda_in),
            .o_sda_o      (sda_o),
            .o_sda_oe     (sda_oe),
            .i_enable     (en[g]),
            .i_dev_addr   (dev[g]),
            .i_write_mode (ctrl[`CTRL_WRITE_MODE]),
            .i_timeout_en (ctrl[`CTRL_TIMEOUT_EN]),
            .i_hs_cont    (ctrl[`CTRL_HS_CONT]),
            .i_rd_data    (rdata[g]),
            .o_ptr        (ptr[g]),
            .o_we         (we[g]),
            .o_wdata      (wdata[g]),
            .o_match      (match[g]),
            .o_busy       (busy[g]),
            .o_hs         (hs[g])
         );
      end
   endgenerate

   assign o_sda     = g_port[0].sda_o;
   assign o_sda_oe  = g_port[0].sda_oe;
   assign o_sda2    = g_port[1].sda_o;
   assign o_sda2_oe = g_port[1].sda_oe;

   // Register space store; primary port wins a same-cycle clash
   logic       mw;
   logic [7:0] ma;
   logic [7:0] md;
   always_comb begin
      mw = we[0] | we[1];
      ma = we[0] ? ptr[0] : ptr[1];
      md = we[0] ? wdata[0] : wdata[1];
   end
   always_ff @(posedge i_clock) begin
      if (mw && ma != `PAGE_CTRL_ADDR && ma < `REG_LIMIT)
         mem[{page, ma}] <= md;
   end

   // Wishbone slave: one wait state, registered ack and data
   logic        hit;
   logic        next_ack;
   logic [31:0] next_dat;
   logic [7:0]  next_ctrl;
   logic [15:0] next_base;
   logic        next_flag;
   logic        next_mask;
   logic        next_page;
   assign hit = i_wb_cyc & i_wb_stb & ~o_wb_ack;
   always_comb begin
      next_ack  = hit;
      next_dat  = o_wb_dat;
      next_ctrl = ctrl;
      next_base = base;
      next_mask = mask;
      next_flag = flag;
      next_page = page;
      if (hit && !i_wb_we) begin
         case (i_wb_adr)
            `CTRL_OFS:   next_dat = {24'h0, ctrl};
            `ADDR_OFS:   next_dat = {16'h0, base};
            `STATUS_OFS: next_dat = {27'h0, hs, busy, flag};
            `MASK_OFS:   next_dat = {31'h0, mask};
            default:     next_dat = 32'h0;
         endcase
      end
      if (hit && i_wb_we) begin
         case (i_wb_adr)
            `CTRL_OFS: if (i_wb_sel[0]) next_ctrl = i_wb_dat[7:0];
            `ADDR_OFS: begin
               if (i_wb_sel[0]) next_base[7:0]  = i_wb_dat[7:0];
               if (i_wb_sel[1]) next_base[15:8] = i_wb_dat[15:8];
            end
            `STATUS_OFS: if (i_wb_sel[0] && i_wb_dat[`STAT_EVENT]) next_flag = 1'b0;
            `MASK_OFS: if (i_wb_sel[0]) next_mask = i_wb_dat[0];
            default: next_dat = o_wb_dat;
         endcase
      end
      // A new access wins over a clear in the same cycle
      if (match[1])
         next_flag = 1'b1;
      if (mw && ma == `PAGE_CTRL_ADDR)
         next_page = md[`PAGE_BIT];
   end

   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h0;
         ctrl     <= `CTRL_RESET;
         base     <= `ADDR_RESET;
         flag     <= 1'b0;
         mask     <= `MASK_RESET;
         page     <= 1'b0;
         o_wake   <= 1'b0;
      end else begin
         o_wb_ack <= next_ack;
         o_wb_dat <= next_dat;
         ctrl     <= next_ctrl;
         base     <= next_base;
         flag     <= next_flag;
         mask     <= next_mask;
         page     <= next_page;
         o_wake   <= match[1] & ctrl[`CTRL_PIN14_WEN];
      end
   end

   // Pin15 controls are overridden while the second port owns pin14
   assign o_pin15_function_select = ctrl[`CTRL_PIN15_SEL] & ~ctrl[`CTRL_PIN14_SEL];
   assign o_pin15_wake_enable     = ctrl[`CTRL_PIN15_WEN] & ~ctrl[`CTRL_PIN14_SEL];
   assign o_interrupt_request_out_n = ~(flag & ~mask);
endmodule : two_wire_register_slave

// File: two_wire_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef TWO_WIRE_REGS_SVH
`define TWO_WIRE_REGS_SVH
// Wishbone register byte offsets
`define CTRL_OFS        4'h0
`define ADDR_OFS        4'h4
`define STATUS_OFS      4'h8
`define MASK_OFS        4'hc
// Control register fields
`define CTRL_PORT_EN    0
`define CTRL_WRITE_MODE 1
`define CTRL_TIMEOUT_EN 2
`define CTRL_HS_CONT    3
`define CTRL_PIN14_SEL  4
`define CTRL_PIN14_WEN  5
`define CTRL_PIN15_WEN  6
`define CTRL_PIN15_SEL  7
`define CTRL_RESET      8'h01
// Address register: primary write address low byte, second port high byte
`define ADDR_RESET      16'hb4b0
// Status register fields
`define STAT_EVENT      0
`define STAT_BUSY0      1
`define STAT_BUSY1      2
`define STAT_HS0        3
`define STAT_HS1        4
`define MASK_RESET      1'b1
// Register space
`define REG_LIMIT       8'h80
`define PAGE_CTRL_ADDR  8'h00
`define PAGE_BIT        1
// Master code prefix 0000 1XXX
`define MCODE_PREFIX    5'h01
// Bus timeout
`define CLOCK_KHZ       40000
`define TIMEOUT_MS      35
`endif
